// [common/oddpc_pkg.sv]
package oddpc_pkg;
	// ==========================================
	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_DIV_A      = 8'h88;
	localparam logic [7:0]  IDX_DIV_B      = 8'h89;
	localparam logic [7:0]  IDX_DIFF_EN    = 8'hB0;
	localparam logic [7:0]  IDX_SE_EN      = 8'hB1;
	localparam logic [7:0]  IDX_ROUTE      = 8'hB5;
	localparam logic [7:0]  IDX_STOP       = 8'hB8;
	localparam logic [7:0]  IDX_STATUS     = 8'hB9;
	localparam logic [7:0]  IDX_CLEAR      = 8'hBA;
	// ==========================================
	// reset values
	localparam logic [23:0] RST_DIV_A      = 24'h000040;
	localparam logic [23:0] RST_DIV_B      = 24'h000040;
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic        RST_STICKY     = 1'b1;
	// ==========================================
	// field layout of the second divider setup
	localparam int          SHAPE_HI       = 23;
	localparam int          SHAPE_LO       = 20;
	localparam logic [3:0]  SHAPE_PULSE    = 4'hF;
	localparam int          BIT_TYPE       = 19;
	localparam int          BIT_POLAR      = 18;
	localparam int          SEL_HI         = 17;
	localparam int          SEL_LO         = 16;
	localparam logic [1:0]  SEL_FIRST_CLK  = 2'h2;
	localparam int          PERIOD_HI      = 15;
	localparam logic [23:0] MAX_RATIO      = 24'hEFFFFF;
	// ==========================================
	// stop control: bit 1 enables the stop, bit 0 is the held level
	localparam int          STOP_A_LO      = 0;
	localparam int          STOP_B_LO      = 2;
	localparam logic [23:0] MIN_RATIO      = 24'h000002;
	// ==========================================
	// bus answers
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// [rtl/oddpc_top.sv]
// Contract
// - second divider shape field all ones selects frame pulse output
// - any other shape value: whole 24-bit value divides, near 50% duty
// - polarity bit: zero regular pulse, one inverted pulse
// - frame pulse on configurable outputs shows opposite polarity
// - type bit: zero boundary mid pulse, one boundary at pulse edge
// - low sixteen bits count related clock periods between frame pulses
// - related clock code 10 is first divider; pulse one related period wide
// - four bits enable differential outputs, clear bit tristates its output
// - two bits enable single-ended outputs, clear bit tristates its output
// - first stop code: 0x run, 10 hold low at fall, 11 hold high at rise
// - second stop code uses the same encoding as the first
// - stopped clock on configurable outputs shows the inverted held level
// - sticky lock-loss flag sets on lock loss and on reset
// - writing one to clear bit clears flag; software then writes zero
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module oddpc_top import oddpc_pkg::*; #(
	parameter int ADDR_W  = 12,
	parameter int RATIO_W = 24,
	parameter int DIFF_N  = 4,
	parameter int SE_N    = 2
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                synth_lock_lost,
	output logic                     first_divided_clock,
	output logic                     second_divided_clock,
	output logic [DIFF_N-1:0]        diff_output,
	output logic [DIFF_N-1:0]        diff_output_oe,
	output logic [SE_N-1:0]          single_ended_output,
	output logic [SE_N-1:0]          single_ended_output_oe,
	output logic [1:0]               config_output
);
	// ==========================================
	// elaboration checks
	if (RATIO_W != 24 || DIFF_N != 4 || SE_N != 2 || ADDR_W < 10 || ADDR_W > 32) begin : g_chk
		$error("oddpc_top: unsupported parameter values");
	end

	// ==========================================
	// state
	typedef struct packed {
		logic              aw_v;
		logic [7:0]        aw_idx;
		logic              w_v;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              b_v;
		logic [1:0]        b_resp;
		logic              r_v;
		logic [31:0]       r_data;
		logic [1:0]        r_resp;
		logic [23:0]       div_a;
		logic [23:0]       div_b;
		logic [7:0]        diff_en;
		logic [7:0]        se_en;
		logic [7:0]        route;
		logic [7:0]        stop;
		logic [7:0]        clr;
		logic              sticky;
		logic [1:0]        lock_sync;
		logic [23:0]       cnt_a;
		logic [23:0]       cnt_b;
		logic              raw_a;
		logic              raw_b;
		logic              out_a;
		logic              out_b;
		logic              held_a;
		logic              held_b;
		logic [15:0]       fp_cnt;
		logic              fp;
		logic [3:0]        diff_act;
		logic [1:0]        se_act;
		logic [1:0]        cfg;
	} oddpc_state_s;

	oddpc_state_s s_q;
	oddpc_state_s s_d;

	// ==========================================
	// helpers
	function automatic logic [23:0] div_step(input logic [23:0] cnt, input logic [23:0] ratio);
		logic [23:0] r;
		r = (ratio < MIN_RATIO) ? MIN_RATIO : ratio;
		div_step = (cnt >= r - 24'h000001) ? 24'h000000 : cnt + 24'h000001;
	endfunction

	function automatic logic div_level(input logic [23:0] cnt, input logic [23:0] ratio);
		logic [23:0] r;
		r = (ratio < MIN_RATIO) ? MIN_RATIO : ratio;
		// odd ratios keep the extra cycle in the high phase
		div_level = cnt < ({1'b0, r[23:1]} + {23'h000000, r[0]});
	endfunction

	// returns {held, out}: a stop freezes on reaching the chosen level, and a
	// release waits until the source matches the held level so no runt appears
	function automatic logic [1:0] stop_step(input logic held, input logic out,
			input logic src, input logic [1:0] code);
		logic h;
		h = held;
		// a new stop level re-arms the hold so the output can travel to it
		if (code[1]) begin
			h = out == code[0];
		end else if (src == out) begin
			h = 1'b0;
		end
		stop_step = {h, h ? out : src};
	endfunction

	logic [7:0]  aw_idx_in;
	logic [7:0]  ar_idx;
	logic        wr_go;
	logic [31:0] cur;
	logic [31:0] wmask;
	logic [31:0] rd;
	logic        rd_hit;
	logic        wr_hit;
	logic        pulse_mode;
	logic        a_next;
	logic        rise_a;
	logic        fall_a;
	logic [15:0] period;
	logic        b_src;
	logic [1:0]  sa;
	logic [1:0]  sb;

	assign aw_idx_in = s_axi_awaddr[9:2];
	assign ar_idx    = s_axi_araddr[9:2];

	always_comb begin
		s_d = s_q;
		cur = 32'h00000000;
		rd = 32'h00000000;
		rd_hit = 1'b1;
		wr_hit = 1'b1;
		wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
		// ==========================================
		// write path: address and data taken in either order
		if (s_axi_awvalid && !s_q.aw_v) begin
			s_d.aw_v = 1'b1;
			s_d.aw_idx = aw_idx_in;
		end
		if (s_axi_wvalid && !s_q.w_v) begin
			s_d.w_v = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		wr_go = s_q.aw_v && s_q.w_v && !s_q.b_v;
		case (s_q.aw_idx)
			IDX_DIV_A:   cur = {8'h00, s_q.div_a};
			IDX_DIV_B:   cur = {8'h00, s_q.div_b};
			IDX_DIFF_EN: cur = {24'h000000, s_q.diff_en};
			IDX_SE_EN:   cur = {24'h000000, s_q.se_en};
			IDX_ROUTE:   cur = {24'h000000, s_q.route};
			IDX_STOP:    cur = {24'h000000, s_q.stop};
			IDX_STATUS:  cur = 32'h00000000;
			IDX_CLEAR:   cur = {24'h000000, s_q.clr};
			default:     wr_hit = 1'b0;
		endcase
		cur = (cur & ~wmask) | (s_q.w_data & wmask);
		if (wr_go) begin
			s_d.aw_v = 1'b0;
			s_d.w_v = 1'b0;
			s_d.b_v = 1'b1;
			s_d.b_resp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			case (s_q.aw_idx)
				IDX_DIV_A:   s_d.div_a = cur[23:0];
				IDX_DIV_B:   s_d.div_b = cur[23:0];
				IDX_DIFF_EN: s_d.diff_en = cur[7:0];
				IDX_SE_EN:   s_d.se_en = cur[7:0];
				IDX_ROUTE:   s_d.route = cur[7:0];
				IDX_STOP:    s_d.stop = cur[7:0];
				IDX_CLEAR:   s_d.clr = cur[7:0];
				default:     s_d.b_resp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			endcase
		end
		if (s_q.b_v && s_axi_bready) begin
			s_d.b_v = 1'b0;
		end
		// ==========================================
		// read path: one cycle to answer
		case (ar_idx)
			IDX_DIV_A:   rd = {8'h00, s_q.div_a};
			IDX_DIV_B:   rd = {8'h00, s_q.div_b};
			IDX_DIFF_EN: rd = {28'h0000000, s_q.diff_en[3:0]};
			IDX_SE_EN:   rd = {30'h00000000, s_q.se_en[1:0]};
			IDX_ROUTE:   rd = {30'h00000000, s_q.route[1:0]};
			IDX_STOP:    rd = {28'h0000000, s_q.stop[3:0]};
			IDX_STATUS:  rd = {31'h00000000, s_q.sticky};
			IDX_CLEAR:   rd = {31'h00000000, s_q.clr[0]};
			default:     rd_hit = 1'b0;
		endcase
		if (s_axi_arvalid && !s_q.r_v) begin
			s_d.r_v = 1'b1;
			s_d.r_data = rd;
			s_d.r_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_q.r_v && s_axi_rready) begin
			s_d.r_v = 1'b0;
		end
		// ==========================================
		// lock loss: set wins over a clear in the same cycle
		s_d.lock_sync = {s_q.lock_sync[0], synth_lock_lost};
		if (s_q.lock_sync[1]) begin
			s_d.sticky = 1'b1;
		end else if (s_q.clr[0]) begin
			s_d.sticky = 1'b0;
		end
		// ==========================================
		// first divider
		s_d.cnt_a = div_step(s_q.cnt_a, s_q.div_a);
		a_next = div_level(s_d.cnt_a, s_q.div_a);
		s_d.raw_a = a_next;
		rise_a = a_next && !s_q.raw_a;
		fall_a = !a_next && s_q.raw_a;
		// ==========================================
		// second divider or frame pulse
		pulse_mode = s_q.div_b[SHAPE_HI:SHAPE_LO] == SHAPE_PULSE;
		period = (s_q.div_b[PERIOD_HI:0] == 16'h0000) ? 16'h0001 : s_q.div_b[PERIOD_HI:0];
		s_d.cnt_b = div_step(s_q.cnt_b, s_q.div_b);
		if (pulse_mode) begin
			s_d.cnt_b = 24'h000000;
			if (rise_a) begin
				s_d.fp_cnt = (s_q.fp_cnt >= period - 16'h0001) ? 16'h0000
					: s_q.fp_cnt + 16'h0001;
			end
			if (s_q.div_b[BIT_TYPE]) begin
				// boundary at the leading edge: high for one related period
				if (rise_a) begin
					s_d.fp = s_q.fp_cnt >= period - 16'h0001;
				end
			end else if (fall_a) begin
				// boundary straddled: falling edge before to falling edge after
				s_d.fp = s_q.fp_cnt >= period - 16'h0001;
			end
		end else begin
			s_d.fp_cnt = 16'h0000;
			s_d.fp = 1'b0;
		end
		s_d.raw_b = div_level(s_d.cnt_b, s_q.div_b);
		// only the first divider may serve as related clock; others give no pulse
		b_src = (s_q.div_b[SEL_HI:SEL_LO] == SEL_FIRST_CLK) && s_q.fp;
		b_src = pulse_mode ? (b_src ^ s_q.div_b[BIT_POLAR]) : s_q.raw_b;
		// ==========================================
		// stop control
		sa = stop_step(s_q.held_a, s_q.out_a, s_q.raw_a, s_q.stop[STOP_A_LO +: 2]);
		sb = stop_step(s_q.held_b, s_q.out_b, b_src, s_q.stop[STOP_B_LO +: 2]);
		s_d.held_a = sa[1];
		s_d.out_a = sa[0];
		s_d.held_b = sb[1];
		s_d.out_b = sb[0];
		// configurable outputs see the inverted level
		s_d.cfg = {s_q.route[1] & ~s_q.out_b, s_q.route[0] & ~s_q.out_a};
		// ==========================================
		// output enables follow the register only while the source is low
		for (int i = 0; i < 4; i++) begin
			if (!((i < 2) ? s_q.out_a : s_q.out_b)) begin
				s_d.diff_act[i] = s_q.diff_en[i];
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (!((i == 0) ? s_q.out_a : s_q.out_b)) begin
				s_d.se_act[i] = s_q.se_en[i];
			end
		end
		// ==========================================
		// synchronous reset
		if (!aresetn) begin
			s_d = '0;
			s_d.div_a = RST_DIV_A;
			s_d.div_b = RST_DIV_B;
			s_d.diff_en = RST_BYTE;
			s_d.se_en = RST_BYTE;
			s_d.route = RST_BYTE;
			s_d.stop = RST_BYTE;
			s_d.clr = RST_BYTE;
			s_d.sticky = RST_STICKY;
		end
	end

	always_ff @(posedge aclk) begin
		if (ce || !aresetn) begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign s_axi_awready          = !s_q.aw_v;
	assign s_axi_wready           = !s_q.w_v;
	assign s_axi_bvalid           = s_q.b_v;
	assign s_axi_bresp            = s_q.b_resp;
	assign s_axi_arready          = !s_q.r_v;
	assign s_axi_rvalid           = s_q.r_v;
	assign s_axi_rdata            = s_q.r_data;
	assign s_axi_rresp            = s_q.r_resp;
	assign first_divided_clock    = s_q.out_a;
	assign second_divided_clock   = s_q.out_b;
	assign diff_output            = {s_q.out_b, s_q.out_b, s_q.out_a, s_q.out_a};
	assign diff_output_oe         = s_q.diff_act;
	assign single_ended_output    = {s_q.out_b, s_q.out_a};
	assign single_ended_output_oe = s_q.se_act;
	assign config_output          = s_q.cfg;
endmodule
`default_nettype wire

// [testbench/oddpc_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port timing checks
module oddpc_checker #(
	parameter int DIFF_N = 4
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              ce,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              first_divided_clock,
	input wire logic              second_divided_clock,
	input wire logic [DIFF_N-1:0] diff_output_oe,
	input wire logic [1:0]        single_ended_output_oe
);
	default clocking @(posedge aclk); endclocking
	sequence wr_taken;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_up;
		##2 s_axi_bvalid;
	endsequence
	// ==========================================
	// assertions
	wr_answer_a: assert property (disable iff (!aresetn)
		wr_taken |-> b_up) else $error("write answer late");
	rd_answer_a: assert property (disable iff (!aresetn)
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	bresp_hold_a: assert property (disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	ar_block_a: assert property (disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
	reset_idle_a: assert property (!aresetn |=> !s_axi_bvalid && !s_axi_rvalid
		&& !first_divided_clock && diff_output_oe == '0) else $error("reset state wrong");
	oe_edge_a: assert property (disable iff (!aresetn)
		$changed(diff_output_oe[0]) |-> !$past(first_divided_clock)) else $error("oe runt");
	se_oe_edge_a: assert property (disable iff (!aresetn)
		$changed(single_ended_output_oe[1]) |-> !$past(second_divided_clock))
		else $error("single ended oe runt");
	ce_freeze_a: assert property (disable iff (!aresetn)
		!ce |=> $stable(first_divided_clock)) else $error("clock moved while frozen");
endmodule
bind oddpc_top oddpc_checker #(.DIFF_N(DIFF_N)) u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .first_divided_clock, .second_divided_clock,
	.diff_output_oe, .single_ended_output_oe);
`default_nettype wire

// [testbench/output_divider_pulse_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module output_divider_pulse_control_tb import oddpc_pkg::*; ();
	logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, synth_lock_lost, first_divided_clock, second_divided_clock;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, single_ended_output, single_ended_output_oe;
	logic [1:0]  config_output;
	logic [3:0]  diff_output, diff_output_oe;
	int          num_errors = 0, n_checks = 0, hi, per;
	int          rt[3] = '{2, 5, 7};
	oddpc_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.synth_lock_lost, .first_divided_clock, .second_divided_clock, .diff_output,
		.diff_output_oe, .single_ended_output, .single_ended_output_oe, .config_output);
	// ==========================================
	// tasks
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tick(inout int n);
		n++;
		if (n > 400) begin
			num_errors++;
			$display("mismatch %0t wait ran out", $time);
			summarize();
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// samples at the falling edge so the handshake seen is the one the next rise takes
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, b, v;
		logic [1:0] r;
		int n;
		n = 0;
		ta = 0;
		tw = 0;
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			b = s_axi_awvalid && s_axi_awready;
			v = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (b) s_axi_awvalid <= 1'b0;
			if (v) s_axi_wvalid <= 1'b0;
			ta = ta | b;
			tw = tw | v;
			tick(n);
		end while (!(ta && tw));
		do begin
			@(negedge aclk);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			tick(n);
		end while (!b);
		s_axi_bready <= 1'b0;
		chk(r, er);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
		logic a, v;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			a = s_axi_arvalid && s_axi_arready;
			@(posedge aclk);
			if (a) s_axi_arvalid <= 1'b0;
			tick(n);
		end while (!a);
		do begin
			@(negedge aclk);
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			tick(n);
		end while (!v);
		s_axi_rready <= 1'b0;
		chk(d, ed);
		chk(r, er);
		@(posedge aclk);
	endtask
	// high time and period from one rising edge to the next
	// s: 0 first clock, 1 second clock, 2 inverse of the second configurable output
	task automatic meas(input logic [1:0] s, output int h, output int p);
		logic q, c;
		int n;
		n = 0;
		h = 0;
		p = 0;
		c = 1;
		do begin
			q = c;
			@(negedge aclk);
			c = (s == 2'h2) ? ~config_output[1] : (s[0] ? second_divided_clock : first_divided_clock);
			tick(n);
		end while (q || !c);
		do begin
			h += c;
			p++;
			q = c;
			@(negedge aclk);
			c = (s == 2'h2) ? ~config_output[1] : (s[0] ? second_divided_clock : first_divided_clock);
			tick(n);
		end while (q || !c);
		@(posedge aclk);
	endtask
	// ==========================================
	// stimulus
	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, synth_lock_lost, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		ce = 1;
		cyc(4);
		aresetn <= 1'b1;
		rd(IDX_DIV_B, RST_DIV_B, RESP_OKAY);
		rd(IDX_STOP, RST_BYTE, RESP_OKAY);
		rd(IDX_STATUS, RST_STICKY, RESP_OKAY);
		rd(8'h00, 0, RESP_SLVERR);
		wr(8'h00, 5, RESP_SLVERR);
		wr(IDX_DIV_A, 4, RESP_OKAY);
		wr(IDX_ROUTE, 3, RESP_OKAY);
		for (int t = 0; t < 4; t++) begin
			wr(IDX_DIV_B, {8'h0, SHAPE_PULSE, t[1], t[0], SEL_FIRST_CLK, 16'h3}, RESP_OKAY);
			cyc(20);
			meas(1, hi, per);
			chk(per, 12);
			chk(hi, t[0] ? 8 : 4);
			meas(2, hi, per);
			chk(per, 12);
			chk(hi, t[0] ? 8 : 4);
		end
		foreach (rt[i]) begin
			wr(IDX_DIV_B, rt[i], RESP_OKAY);
			cyc(20);
			meas(1, hi, per);
			chk(per, rt[i]);
			chk(hi, (rt[i] + 1) / 2);
		end
		rd(IDX_DIV_B, 7, RESP_OKAY);
		wr(IDX_DIFF_EN, 4'h5, RESP_OKAY);
		wr(IDX_SE_EN, 2'h2, RESP_OKAY);
		cyc(20);
		chk(diff_output_oe, 4'h5);
		chk(single_ended_output_oe, 2'h2);
		rd(IDX_SE_EN, 2'h2, RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			wr(IDX_STOP, {c[1:0], c[1:0]}, RESP_OKAY);
			cyc(30);
			if (c < 2) begin
				meas(0, hi, per);
				chk(per, 4);
			end else begin
				chk(first_divided_clock, c[0]);
				chk(second_divided_clock, c[0]);
				chk(config_output, {2{~c[0]}});
				chk(diff_output, {4{c[0]}});
				chk(single_ended_output, {2{c[0]}});
			end
		end
		wr(IDX_CLEAR, 1, RESP_OKAY);
		wr(IDX_CLEAR, 0, RESP_OKAY);
		rd(IDX_STATUS, 0, RESP_OKAY);
		synth_lock_lost <= 1'b1;
		cyc(4);
		synth_lock_lost <= 1'b0;
		cyc(4);
		wr(IDX_STATUS, 0, RESP_OKAY);
		rd(IDX_STATUS, 1, RESP_OKAY);
		wr(IDX_STOP, 0, RESP_OKAY);
		ce <= 1'b0;
		cyc(10);
		ce <= 1'b1;
		cyc(2);
		wr(IDX_CLEAR, 1, RESP_OKAY);
		wr(IDX_CLEAR, 0, RESP_OKAY);
		rd(IDX_STATUS, 0, RESP_OKAY);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		rd(IDX_STATUS, RST_STICKY, RESP_OKAY);
		rd(IDX_DIFF_EN, RST_BYTE, RESP_OKAY);
		summarize();
	end
endmodule
`default_nettype wire
